/* File: hdl/ctm_pkg.sv */
// Constants and state layout for the clock timer and its interrupt logic.
package ctm_pkg;

    // ----------------------------------------
    // Register indices and byte addresses
    // ----------------------------------------
    localparam logic [15:0] CTM_IDX_PRIO = 16'hFF20;
    localparam logic [15:0] CTM_IDX_EN = 16'hFF22;
    localparam logic [15:0] CTM_IDX_FLAG = 16'hFF24;
    localparam logic [15:0] CTM_IDX_CTRL = 16'hFF40;
    localparam logic [15:0] CTM_IDX_VALUE = 16'hFF41;
    localparam logic [17:0] CTM_ADDR_PRIO = {CTM_IDX_PRIO, 2'h0};
    localparam logic [17:0] CTM_ADDR_EN = {CTM_IDX_EN, 2'h0};
    localparam logic [17:0] CTM_ADDR_FLAG = {CTM_IDX_FLAG, 2'h0};
    localparam logic [17:0] CTM_ADDR_CTRL = {CTM_IDX_CTRL, 2'h0};
    localparam logic [17:0] CTM_ADDR_VALUE = {CTM_IDX_VALUE, 2'h0};

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTM_CTRL_RUN = 0;
    localparam int CTM_CTRL_CLR = 1;
    localparam int CTM_SRC_1HZ = 0;
    localparam int CTM_SRC_2HZ = 1;
    localparam int CTM_SRC_8HZ = 2;
    localparam int CTM_SRC_MIN = 3;
    localparam int CTM_STAGE_8HZ = 4;
    localparam int CTM_STAGE_2HZ = 6;
    localparam int CTM_STAGE_1HZ = 7;

    // ----------------------------------------
    // Reset values, counts and vectors
    // ----------------------------------------
    localparam logic [7:0] CTM_CNT_RST = 8'h00;
    localparam logic [5:0] CTM_SEC_RST = 6'h00;
    localparam logic [5:0] CTM_SEC_LAST = 6'h3B;
    localparam logic [23:0] CTM_VEC_MIN = 24'h00001C;
    localparam logic [23:0] CTM_VEC_8HZ = 24'h00001E;
    localparam logic [23:0] CTM_VEC_2HZ = 24'h000020;
    localparam logic [23:0] CTM_VEC_1HZ = 24'h000022;

    typedef struct packed {
        logic tick_s1;
        logic tick_s2;
        logic tick_s3;
        logic [7:0] cnt;
        logic [5:0] sec;
        logic run;
        logic [1:0] prio;
        logic [3:0] en;
        logic [3:0] flg;
        logic [31:0] rdata;
        logic rerr;
        logic irq;
        logic [23:0] vec;
    } ctm_state_t;

endpackage

/* File: hdl/ctm_clock_timer.sv */
// Clock timer with run/stop, clear, tick flags and an APB register slave.
`timescale 1ns/1ns
`default_nettype none
module ctm_clock_timer
    import ctm_pkg::*;
(
    // Clock, reset and enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Slow oscillator tick from the divider chain
    input wire logic tick256,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt request
    output logic irq,
    output logic [1:0] irq_level,
    output logic [23:0] irq_vector
);

    // ----------------------------------------
    // Decoding
    // ----------------------------------------
    function automatic logic mapped(input logic [17:0] a);
        mapped = (a == CTM_ADDR_PRIO) || (a == CTM_ADDR_EN) || (a == CTM_ADDR_FLAG) ||
                 (a == CTM_ADDR_CTRL) || (a == CTM_ADDR_VALUE);
    endfunction

    ctm_state_t s_q;
    ctm_state_t s_d;
    logic setup;
    logic wr;
    logic tick;
    logic clr;
    logic [7:0] cnt_inc;
    logic fall8;
    logic fall2;
    logic fall1;
    logic min_tick;
    logic [3:0] set;
    logic [3:0] wclr;

    assign setup = psel && !penable;
    assign pready = psel && penable && ce;
    assign wr = pready && pwrite;
    assign tick = s_q.tick_s2 && !s_q.tick_s3;
    assign clr = wr && (paddr == CTM_ADDR_CTRL) && pwdata[CTM_CTRL_CLR];
    assign cnt_inc = s_q.cnt + 8'h01;
    assign fall8 = s_q.run && tick && !clr && s_q.cnt[CTM_STAGE_8HZ] && !cnt_inc[CTM_STAGE_8HZ];
    assign fall2 = s_q.run && tick && !clr && s_q.cnt[CTM_STAGE_2HZ] && !cnt_inc[CTM_STAGE_2HZ];
    assign fall1 = s_q.run && tick && !clr && s_q.cnt[CTM_STAGE_1HZ] && !cnt_inc[CTM_STAGE_1HZ];
    assign min_tick = fall1 && (s_q.sec == CTM_SEC_LAST);
    assign wclr = (wr && (paddr == CTM_ADDR_FLAG)) ? pwdata[3:0] : 4'h0;

    always_comb begin
        set = 4'h0;
        set[CTM_SRC_8HZ] = fall8;
        set[CTM_SRC_2HZ] = fall2;
        set[CTM_SRC_1HZ] = fall1;
        set[CTM_SRC_MIN] = min_tick;
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        // The oscillator tick is foreign to pclk, so it passes two flops first.
        s_d.tick_s1 = tick256;
        s_d.tick_s2 = s_q.tick_s1;
        s_d.tick_s3 = s_q.tick_s2;
        if (clr) begin
            s_d.cnt = CTM_CNT_RST;
            s_d.sec = CTM_SEC_RST;
        end else if (s_q.run && tick) begin
            s_d.cnt = cnt_inc;
            if (fall1) begin
                s_d.sec = min_tick ? CTM_SEC_RST : s_q.sec + 6'h01;
            end
        end
        if (wr && (paddr == CTM_ADDR_CTRL)) begin
            s_d.run = pwdata[CTM_CTRL_RUN];
        end
        if (wr && (paddr == CTM_ADDR_PRIO)) begin
            s_d.prio = pwdata[1:0];
        end
        if (wr && (paddr == CTM_ADDR_EN)) begin
            s_d.en = pwdata[3:0];
        end
        // A tick landing on the clearing write still leaves its flag set.
        s_d.flg = (s_q.flg & ~wclr) | set;
        if (setup) begin
            s_d.rerr = !mapped(paddr);
            unique case (paddr)
                CTM_ADDR_PRIO: s_d.rdata = {30'h0, s_q.prio};
                CTM_ADDR_EN: s_d.rdata = {28'h0, s_q.en};
                CTM_ADDR_FLAG: s_d.rdata = {28'h0, s_q.flg};
                CTM_ADDR_CTRL: s_d.rdata = {31'h0, s_q.run};
                CTM_ADDR_VALUE: s_d.rdata = {24'h0, s_q.cnt};
                default: s_d.rdata = 32'h0;
            endcase
        end
        s_d.irq = |(s_d.flg & s_d.en);
        if (s_d.flg[CTM_SRC_MIN] && s_d.en[CTM_SRC_MIN]) begin
            s_d.vec = CTM_VEC_MIN;
        end else if (s_d.flg[CTM_SRC_8HZ] && s_d.en[CTM_SRC_8HZ]) begin
            s_d.vec = CTM_VEC_8HZ;
        end else if (s_d.flg[CTM_SRC_2HZ] && s_d.en[CTM_SRC_2HZ]) begin
            s_d.vec = CTM_VEC_2HZ;
        end else begin
            s_d.vec = CTM_VEC_1HZ;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign pslverr = s_q.rerr;
    assign irq = s_q.irq;
    assign irq_level = s_q.prio;
    assign irq_vector = s_q.vec;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
        ce && s_q.run && tick && !clr |=> s_q.cnt == $past(s_q.cnt) + 8'h01)
        else $error("Counter did not step on tick.");

    a_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !s_q.run && !clr |=> $stable(s_q.cnt))
        else $error("Stopped counter changed.");

    a_clear_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ce && clr |=> s_q.cnt == 8'h00 && s_q.sec == 6'h00)
        else $error("Clear did not zero the counters.");

    a_sec_range: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.sec <= 6'h3B)
        else $error("Seconds counter out of range.");

    a_flag8_set: assert property (@(posedge pclk) disable iff (!presetn)
        ce && s_q.run && tick && !clr && s_q.cnt[4:0] == 5'h1F |=> s_q.flg[2])
        else $error("8 Hz flag not set on falling edge.");

    a_minute_tick: assert property (@(posedge pclk) disable iff (!presetn)
        ce && fall1 && s_q.sec == 6'h3B |=> s_q.flg[3] && s_q.sec == 6'h00)
        else $error("Minute tick missing at wrap.");

    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.flg[0] && !(ce && wr && paddr == CTM_ADDR_FLAG && pwdata[0]) |=> s_q.flg[0])
        else $error("Pending flag dropped without a clearing write.");

    a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(s_q.flg & s_q.en))
        else $error("Interrupt does not match enabled flags.");

    a_vector_min: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.flg[3] && s_q.en[3] |-> irq_vector == 24'h00001C)
        else $error("Minute vector wrong.");

    a_value_read: assert property (@(posedge pclk) disable iff (!presetn)
        ce && setup && paddr == CTM_ADDR_VALUE |=> prdata == {24'h0, $past(s_q.cnt)})
        else $error("Value read does not show the counter.");

    a_clear_reads0: assert property (@(posedge pclk) disable iff (!presetn)
        ce && setup && paddr == CTM_ADDR_CTRL |=> prdata[1] == 1'b0)
        else $error("Clear bit read back as one.");

    a_run_write: assert property (@(posedge pclk) disable iff (!presetn)
        ce && wr && paddr == CTM_ADDR_CTRL |=> s_q.run == $past(pwdata[0]))
        else $error("Run bit not written.");

    a_freeze_count: assert property (@(posedge pclk) disable iff (!presetn)
        !ce
        |=> s_q.cnt == $past(s_q.cnt))
        else $error("Counter moved while the enable was low.");

    a_freeze_flags: assert property (@(posedge pclk) disable iff (!presetn)
        !ce
        |=> s_q.flg == $past(s_q.flg))
        else $error("Flags moved while the enable was low.");

    a_tick_single: assert property (@(posedge pclk) disable iff (!presetn)
        ce && tick
        |=> !tick)
        else $error("One oscillator edge gave two ticks.");

    a_count_notick: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !tick && !clr
        |=> s_q.cnt == $past(s_q.cnt))
        else $error("Counter moved without a tick.");

    a_sec_hold: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !fall1 && !clr
        |=> s_q.sec == $past(s_q.sec))
        else $error("Seconds moved without a 1 Hz fall.");

    a_sec_step: assert property (@(posedge pclk) disable iff (!presetn)
        ce && fall1 && s_q.sec != CTM_SEC_LAST
        |=> s_q.sec == $past(s_q.sec) + 6'h01)
        else $error("Seconds did not step on a 1 Hz fall.");

    a_sec_stopped: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !s_q.run && !clr
        |=> s_q.sec == $past(s_q.sec))
        else $error("Seconds moved while stopped.");

    a_clear_run: assert property (@(posedge pclk) disable iff (!presetn)
        ce && clr && pwdata[CTM_CTRL_RUN]
        |=> s_q.run && s_q.cnt == CTM_CNT_RST)
        else $error("Clear while running did not keep running from zero.");

    a_clear_stopped: assert property (@(posedge pclk) disable iff (!presetn)
        ce && clr && !pwdata[CTM_CTRL_RUN]
        |=> !s_q.run && s_q.cnt == CTM_CNT_RST)
        else $error("Clear while stopping did not hold zero.");

    a_clear_noflag: assert property (@(posedge pclk) disable iff (!presetn)
        ce && clr
        |=> (s_q.flg & ~$past(s_q.flg)) == 4'h0)
        else $error("Clear raised a pending flag.");

    a_restart_keep: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !s_q.run && wr && paddr == CTM_ADDR_CTRL && pwdata[CTM_CTRL_RUN] && !pwdata[CTM_CTRL_CLR]
        |=> s_q.cnt == $past(s_q.cnt))
        else $error("Restart lost the kept count.");

    a_flag2_set: assert property (@(posedge pclk) disable iff (!presetn)
        ce && s_q.run && tick && !clr && s_q.cnt[6:0] == 7'h7F
        |=> s_q.flg[CTM_SRC_2HZ])
        else $error("2 Hz flag not set on falling edge.");

    a_flag1_set: assert property (@(posedge pclk) disable iff (!presetn)
        ce && s_q.run && tick && !clr && s_q.cnt == 8'hFF
        |=> s_q.flg[CTM_SRC_1HZ])
        else $error("1 Hz flag not set on falling edge.");

    a_flag_notick: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !tick
        |=> (s_q.flg & ~$past(s_q.flg)) == 4'h0)
        else $error("Flag raised without a tick.");

    a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
        ce && wr && paddr == CTM_ADDR_FLAG && pwdata[CTM_SRC_1HZ] && !set[CTM_SRC_1HZ]
        |=> !s_q.flg[CTM_SRC_1HZ])
        else $error("Writing one did not clear the flag.");

    a_flag_setwins: assert property (@(posedge pclk) disable iff (!presetn)
        ce && set[CTM_SRC_8HZ]
        |=> s_q.flg[CTM_SRC_8HZ])
        else $error("A clearing write beat a new event.");

    a_sticky_8hz: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.flg[CTM_SRC_8HZ] && !(ce && wr && paddr == CTM_ADDR_FLAG && pwdata[CTM_SRC_8HZ])
        |=> s_q.flg[CTM_SRC_8HZ])
        else $error("8 Hz flag dropped without a clearing write.");

    a_sticky_min: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.flg[CTM_SRC_MIN] && !(ce && wr && paddr == CTM_ADDR_FLAG && pwdata[CTM_SRC_MIN])
        |=> s_q.flg[CTM_SRC_MIN])
        else $error("Minute flag dropped without a clearing write.");

    a_min_early: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !s_q.flg[CTM_SRC_MIN] && !(fall1 && s_q.sec == CTM_SEC_LAST)
        |=> !s_q.flg[CTM_SRC_MIN])
        else $error("Minute flag set before the seconds wrap.");

    a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.en == 4'h0
        |-> !irq)
        else $error("Interrupt raised with every source disabled.");

    a_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
        ce && |(set & s_d.en)
        |=> irq)
        else $error("Enabled event gave no interrupt.");

    a_en_write: assert property (@(posedge pclk) disable iff (!presetn)
        ce && wr && paddr == CTM_ADDR_EN
        |=> s_q.en == $past(pwdata[3:0]))
        else $error("Enable bits not written.");

    a_en_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(ce && wr && paddr == CTM_ADDR_EN)
        |=> s_q.en == $past(s_q.en))
        else $error("Enable bits changed without a write.");

    a_level_write: assert property (@(posedge pclk) disable iff (!presetn)
        ce && wr && paddr == CTM_ADDR_PRIO
        |=> irq_level == $past(pwdata[1:0]))
        else $error("Priority level not written.");

    a_level_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(ce && wr && paddr == CTM_ADDR_PRIO)
        |=> irq_level == $past(irq_level))
        else $error("Priority level changed without a write.");

    a_vector_8hz: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.flg[CTM_SRC_8HZ] && s_q.en[CTM_SRC_8HZ] && !(s_q.flg[CTM_SRC_MIN] && s_q.en[CTM_SRC_MIN])
        |-> irq_vector == CTM_VEC_8HZ)
        else $error("8 Hz vector wrong.");

    a_vector_2hz: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.flg[CTM_SRC_2HZ] && s_q.en[CTM_SRC_2HZ] && !(|(s_q.flg[3:2] & s_q.en[3:2]))
        |-> irq_vector == CTM_VEC_2HZ)
        else $error("2 Hz vector wrong.");

    a_vector_1hz: assert property (@(posedge pclk) disable iff (!presetn)
        irq && !(|(s_q.flg[3:1] & s_q.en[3:1]))
        |-> irq_vector == CTM_VEC_1HZ)
        else $error("1 Hz vector wrong.");

    a_run_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(ce && wr && paddr == CTM_ADDR_CTRL)
        |=> s_q.run == $past(s_q.run))
        else $error("Run bit changed without a write.");

    a_ctrl_read: assert property (@(posedge pclk) disable iff (!presetn)
        ce && setup && paddr == CTM_ADDR_CTRL
        |=> prdata == {31'h0, $past(s_q.run)})
        else $error("Control read does not show the run bit.");

    a_value_ro: assert property (@(posedge pclk) disable iff (!presetn)
        ce && wr && paddr == CTM_ADDR_VALUE && !(s_q.run && tick)
        |=> s_q.cnt == $past(s_q.cnt))
        else $error("Write to the value register changed the counter.");

    a_rdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(ce && setup)
        |=> prdata == $past(prdata))
        else $error("Read data changed outside a setup cycle.");

    a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        ce && setup && !mapped(paddr)
        |=> pslverr && prdata == 32'h0)
        else $error("Unmapped read not flagged.");

    a_ready_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !ce
        |-> !pready)
        else $error("Ready raised while the enable was low.");

endmodule
`default_nettype wire

/* File: sim/tb_clock_timer_interrupts.sv */
// Self-checking testbench for the clock timer with its APB registers and tick interrupts.
`timescale 1ns/1ns
`default_nettype none
module tb_clock_timer_interrupts
    import ctm_pkg::*;
;
    // ----------------------------------------
    // Signals and counters
    // ----------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic tick256 = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [1:0] irq_level;
    logic [23:0] irq_vector;
    logic [31:0] rdv;
    logic last_err;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;

    ctm_clock_timer dut (.pclk(pclk), .presetn(presetn), .ce(ce), .tick256(tick256), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .irq_level(irq_level), .irq_vector(irq_vector));

    always #20 pclk = ~pclk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic finish_test();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // The whole minute scenario alone needs about 77000 cycles.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input string nm, input logic [17:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk(nm, e, rdv);
    endtask

    // Five cycles per tick keeps the synchroniser's two-cycle minimum spacing with margin.
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge pclk);
            tick256 <= 1'b1;
            repeat (2) @(posedge pclk);
            tick256 <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        repeat (2) @(posedge pclk);
    endtask

    task automatic irq_chk(input logic e_irq, input logic [23:0] e_vec);
        @(negedge pclk);
        chk("irq", {31'h0, e_irq}, {31'h0, irq});
        chk("irq_vector", {8'h00, e_vec}, {8'h00, irq_vector});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_run_stop();
        rd("value", CTM_ADDR_VALUE, 32'h00000000);
        rd("ctrl", CTM_ADDR_CTRL, 32'h00000000);
        apb(1'b1, CTM_ADDR_VALUE, 32'h000000FF);
        tick(3);
        rd("value", CTM_ADDR_VALUE, 32'h00000000);
        apb(1'b1, CTM_ADDR_CTRL, 32'h00000001);
        tick(5);
        rd("value", CTM_ADDR_VALUE, 32'h00000005);
        rd("ctrl", CTM_ADDR_CTRL, 32'h00000001);
        apb(1'b1, CTM_ADDR_CTRL, 32'h00000000);
        tick(3);
        rd("value", CTM_ADDR_VALUE, 32'h00000005);
        apb(1'b1, CTM_ADDR_CTRL, 32'h00000001);
        tick(2);
        rd("value", CTM_ADDR_VALUE, 32'h00000007);
        ce <= 1'b0;
        tick(2);
        ce <= 1'b1;
        rd("value", CTM_ADDR_VALUE, 32'h00000007);
    endtask

    task automatic t_clear();
        apb(1'b1, CTM_ADDR_CTRL, 32'h00000003);
        rd("value", CTM_ADDR_VALUE, 32'h00000000);
        rd("ctrl", CTM_ADDR_CTRL, 32'h00000001);
        tick(1);
        rd("value", CTM_ADDR_VALUE, 32'h00000001);
        apb(1'b1, CTM_ADDR_CTRL, 32'h00000002);
        tick(2);
        rd("value", CTM_ADDR_VALUE, 32'h00000000);
    endtask

    task automatic t_flags();
        apb(1'b1, CTM_ADDR_PRIO, 32'h00000003);
        apb(1'b1, CTM_ADDR_EN, 32'h00000004);
        apb(1'b1, CTM_ADDR_CTRL, 32'h00000001);
        tick(31);
        rd("flag", CTM_ADDR_FLAG, 32'h00000000);
        tick(1);
        rd("value", CTM_ADDR_VALUE, 32'h00000020);
        rd("flag", CTM_ADDR_FLAG, 32'h00000004);
        chk("irq_level", 32'h00000003, {30'h0, irq_level});
        irq_chk(1'b1, CTM_VEC_8HZ);
        apb(1'b1, CTM_ADDR_EN, 32'h00000000);
        irq_chk(1'b0, CTM_VEC_1HZ);
        apb(1'b1, CTM_ADDR_FLAG, 32'h00000000);
        rd("flag", CTM_ADDR_FLAG, 32'h00000004);
        apb(1'b1, CTM_ADDR_FLAG, 32'h00000004);
        rd("flag", CTM_ADDR_FLAG, 32'h00000000);
        apb(1'b1, CTM_ADDR_EN, 32'h00000004);
        irq_chk(1'b0, CTM_VEC_1HZ);
        apb(1'b0, 18'h00010, 32'h00000000);
        chk("pslverr", 32'h00000001, {31'h0, last_err});
        chk("unmapped", 32'h00000000, rdv);
    endtask

    task automatic t_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd("value", CTM_ADDR_VALUE, 32'h00000000);
        rd("ctrl", CTM_ADDR_CTRL, 32'h00000000);
        rd("flag", CTM_ADDR_FLAG, 32'h00000000);
        chk("irq_level", 32'h00000000, {30'h0, irq_level});
        irq_chk(1'b0, CTM_VEC_1HZ);
    endtask

    // The minute tick must come at exactly 60 seconds of 256 Hz counting.
    task automatic t_minute();
        apb(1'b1, CTM_ADDR_CTRL, 32'h00000003);
        apb(1'b1, CTM_ADDR_EN, 32'h00000008);
        apb(1'b1, CTM_ADDR_FLAG, 32'h0000000F);
        tick(15359);
        rd("flag", CTM_ADDR_FLAG, 32'h00000007);
        tick(1);
        rd("flag", CTM_ADDR_FLAG, 32'h0000000F);
        rd("value", CTM_ADDR_VALUE, 32'h00000000);
        irq_chk(1'b1, CTM_VEC_MIN);
        apb(1'b1, CTM_ADDR_EN, 32'h00000006);
        irq_chk(1'b1, CTM_VEC_8HZ);
        apb(1'b1, CTM_ADDR_FLAG, 32'h00000004);
        irq_chk(1'b1, CTM_VEC_2HZ);
        apb(1'b1, CTM_ADDR_EN, 32'h00000001);
        irq_chk(1'b1, CTM_VEC_1HZ);
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_run_stop();
        t_clear();
        t_flags();
        t_reset();
        t_minute();
        finish_test();
    end
endmodule
`default_nettype wire
